// File: rtl/adc_result_limit_zero_cross.sv
/*
 * Result storage, offset subtraction, limit checks and sign-change detection
 * for eight conversion slots, with an APB register slave.
 * Assumes conversions arrive as one-cycle strobes on the module clock.
 */
// Behaviour
// - Raw above high bound sets high flag
// - Raw below low bound sets low flag
// - Status flags sticky, cleared by writing one
// - High flag with enable raises interrupt
// - Permitted sign change sets crossing flag
// - Crossing flag with enable raises interrupt
// - No crossing flag when disabled or unchanged
// - Eight results, slot n to register n
// - Parallel pair slots zero, four to registers
// - Software write uses field, subtracts offset
// - Bit 15 flags negative, two's complement
// - Result bits 14..3, low three zero
// - Limits compare raw value before offset
// - 0x7ff8 high, 0x0000 low disable checks
// - Reset leaves limit checks disabled
// - Result is raw minus slot offset
// - Reading result clears its ready flag
// - Summary clears when all flags cleared
`timescale 1ns/1ns

module adc_result_limit_zero_cross
    import adc_post_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Conversion input
    input  wire logic        conv_valid_i,
    input  wire logic [2:0]  conv_slot_i,
    input  wire logic [15:0] conv_raw_i,
    // Interrupt request
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0][15:0] result;
        logic [7:0][15:0] low_bound;
        logic [7:0][15:0] high_bound;
        logic [7:0][15:0] offset;
        logic [7:0]       high_flag;
        logic [7:0]       low_flag;
        logic [7:0]       cross_flag;
        logic [7:0]       ready;
        logic [7:0]       prev_neg;
        logic [7:0]       seen;
        logic [2:0]       control_one;
        logic [15:0]      crossing_control;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
    } state_t;

    state_t st;
    state_t next_st;

    // Word index of an address inside an eight-register bank, or 4'hf if outside
    function automatic logic [3:0] bank_index(input logic [11:0] addr, input logic [11:0] base);
        logic [11:0] diff;
        diff = addr - base;
        if (addr >= base && diff < 12'h020 && diff[1:0] == 2'b00) begin
            bank_index = {1'b0, diff[4:2]};
        end else begin
            bank_index = 4'hf;
        end
    endfunction

    // Offset subtraction; sign from the difference only
    function automatic logic [15:0] corrected(input logic [15:0] raw, input logic [15:0] ofs);
        logic [15:0] diff;
        diff = (raw & VALUE_MASK) - (ofs & VALUE_MASK);
        corrected = {diff[NEG_BIT], diff[VALUE_MSB:VALUE_LSB], 3'b000};
    endfunction

    function automatic logic cross_hit(input logic [1:0] sel, input logic was_neg,
                                       input logic is_neg);
        case (sel)
            CROSS_POS_NEG: cross_hit = !was_neg && is_neg;
            CROSS_NEG_POS: cross_hit = was_neg && !is_neg;
            CROSS_ANY:     cross_hit = was_neg != is_neg;
            default:       cross_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic        acc_phase;
    logic        wr_acc;
    logic        rd_acc;
    logic [3:0]  res_idx;
    logic [3:0]  low_idx;
    logic [3:0]  high_idx;
    logic [3:0]  ofs_idx;
    logic [15:0] raw_v;
    logic [7:0]  high_set;
    logic [7:0]  low_set;
    logic [7:0]  cross_set;
    logic [7:0]  ready_set;
    logic [7:0]  w1c_mask;
    logic        raw_neg;
    logic [1:0]  sel;

    assign acc_phase = psel_i && penable_i && !st.pready;
    assign wr_acc    = acc_phase && pwrite_i;
    assign rd_acc    = acc_phase && !pwrite_i;
    assign res_idx   = bank_index(paddr_i, ADDR_RESULT_BASE);
    assign low_idx   = bank_index(paddr_i, ADDR_LOW_BASE);
    assign high_idx  = bank_index(paddr_i, ADDR_HIGH_BASE);
    assign ofs_idx   = bank_index(paddr_i, ADDR_OFFSET_BASE);
    assign raw_v     = conv_raw_i & VALUE_MASK;
    assign raw_neg   = raw_v[VALUE_MSB];
    assign sel       = st.crossing_control[2*conv_slot_i +: 2];

    // Compare events from the raw sample, before offset
    always_comb begin
        high_set  = 8'h00;
        low_set   = 8'h00;
        cross_set = 8'h00;
        ready_set = 8'h00;
        if (conv_valid_i) begin
            ready_set[conv_slot_i] = 1'b1;
            // Bound at its disabling value cannot trip: raw never exceeds 0x7ff8 nor below 0
            high_set[conv_slot_i]  = raw_v > st.high_bound[conv_slot_i];
            low_set[conv_slot_i]   = raw_v < st.low_bound[conv_slot_i];
            // First sample of a slot has no predecessor to compare with
            cross_set[conv_slot_i] = st.seen[conv_slot_i]
                                     && cross_hit(sel, st.prev_neg[conv_slot_i], raw_neg);
        end
    end

    always_comb begin
        next_st         = st;
        next_st.pready  = acc_phase;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        w1c_mask        = 8'h00;

        // Slot n lands in result n unless a same-cycle write to result n wins; this also covers parallel pairs 0 and 4
        if (conv_valid_i) begin
            next_st.result[conv_slot_i]   = corrected(conv_raw_i, st.offset[conv_slot_i]);
            next_st.prev_neg[conv_slot_i] = raw_neg;
            next_st.seen[conv_slot_i]     = 1'b1;
        end

        if (wr_acc) begin
            if (paddr_i == ADDR_LIMIT_STATUS) begin
                next_st.high_flag = st.high_flag & ~pwdata_i[15:8];
                next_st.low_flag  = st.low_flag & ~pwdata_i[7:0];
            end else if (paddr_i == ADDR_ZERO_CROSS_STAT) begin
                w1c_mask           = pwdata_i[7:0];
                next_st.cross_flag = st.cross_flag & ~w1c_mask;
            end else if (paddr_i == ADDR_CONTROL_ONE) begin
                next_st.control_one = pwdata_i[2:0];
            end else if (paddr_i == ADDR_CROSSING_CONTROL) begin
                next_st.crossing_control = pwdata_i[15:0];
            end else if (paddr_i == ADDR_MAIN_STATUS) begin
                next_st.pslverr = 1'b0;
            end else if (!res_idx[3]) begin
                next_st.result[res_idx[2:0]] = corrected(pwdata_i[15:0],
                                                         st.offset[res_idx[2:0]]);
            end else if (!low_idx[3]) begin
                next_st.low_bound[low_idx[2:0]] = pwdata_i[15:0] & VALUE_MASK;
            end else if (!high_idx[3]) begin
                next_st.high_bound[high_idx[2:0]] = pwdata_i[15:0] & VALUE_MASK;
            end else if (!ofs_idx[3]) begin
                next_st.offset[ofs_idx[2:0]] = pwdata_i[15:0] & VALUE_MASK;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        if (rd_acc) begin
            if (paddr_i == ADDR_LIMIT_STATUS) begin
                next_st.prdata = {16'h0000, st.high_flag, st.low_flag};
            end else if (paddr_i == ADDR_ZERO_CROSS_STAT) begin
                next_st.prdata = {24'h000000, st.cross_flag};
            end else if (paddr_i == ADDR_CONTROL_ONE) begin
                next_st.prdata = {29'h00000000, st.control_one};
            end else if (paddr_i == ADDR_CROSSING_CONTROL) begin
                next_st.prdata = {16'h0000, st.crossing_control};
            end else if (paddr_i == ADDR_MAIN_STATUS) begin
                // Summaries follow the sticky flags, so they drop with the last one
                next_st.prdata = {21'h000000, |st.cross_flag, |st.low_flag,
                                  |st.high_flag, st.ready};
            end else if (!res_idx[3]) begin
                next_st.prdata = {16'h0000, st.result[res_idx[2:0]]};
                next_st.ready[res_idx[2:0]] = 1'b0;
            end else if (!low_idx[3]) begin
                next_st.prdata = {16'h0000, st.low_bound[low_idx[2:0]]};
            end else if (!high_idx[3]) begin
                next_st.prdata = {16'h0000, st.high_bound[high_idx[2:0]]};
            end else if (!ofs_idx[3]) begin
                next_st.prdata = {16'h0000, st.offset[ofs_idx[2:0]]};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        // Hardware sets applied last so they beat a same-cycle clear
        next_st.high_flag  = next_st.high_flag | high_set;
        next_st.low_flag   = next_st.low_flag | low_set;
        next_st.cross_flag = next_st.cross_flag | cross_set;
        next_st.ready      = next_st.ready | ready_set;

        next_st.irq = (st.control_one[CTL_HIGH_IE] && |next_st.high_flag)
                    || (st.control_one[CTL_LOW_IE] && |next_st.low_flag)
                    || (st.control_one[CTL_CROSS_IE] && |next_st.cross_flag);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st <= '0;
            for (int i = 0; i < NUM_SAMPLES; i++) begin
                st.high_bound[i] <= HIGH_BOUND_RESET;
                st.low_bound[i]  <= LOW_BOUND_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o  = st.prdata;
    assign pready_o  = st.pready;
    assign pslverr_o = st.pslverr;
    assign irq_o     = st.irq;

endmodule

// File: rtl/adc_post_pkg.sv
/*
 * Constants for the converter result, limit and sign-change post-processing block.
 * Assumes an APB register bus with 32-bit data, one register per aligned word.
 */
package adc_post_pkg;

    localparam int unsigned NUM_SAMPLES = 8;

    // Register byte addresses
    localparam logic [11:0] ADDR_LIMIT_STATUS     = 12'h000;
    localparam logic [11:0] ADDR_ZERO_CROSS_STAT  = 12'h004;
    localparam logic [11:0] ADDR_CONTROL_ONE      = 12'h008;
    localparam logic [11:0] ADDR_CROSSING_CONTROL = 12'h00c;
    localparam logic [11:0] ADDR_MAIN_STATUS      = 12'h010;
    localparam logic [11:0] ADDR_RESULT_BASE      = 12'h040;
    localparam logic [11:0] ADDR_LOW_BASE         = 12'h060;
    localparam logic [11:0] ADDR_HIGH_BASE        = 12'h080;
    localparam logic [11:0] ADDR_OFFSET_BASE      = 12'h0a0;

    // Data field layout
    localparam int unsigned VALUE_MSB    = 14;
    localparam int unsigned VALUE_LSB    = 3;
    localparam int unsigned NEG_BIT      = 15;
    localparam logic [15:0] VALUE_MASK   = 16'h7ff8;

    // Control one bit positions
    localparam int unsigned CTL_HIGH_IE  = 0;
    localparam int unsigned CTL_LOW_IE   = 1;
    localparam int unsigned CTL_CROSS_IE = 2;

    // Main status bit positions
    localparam int unsigned MST_HIGH_SUM  = 8;
    localparam int unsigned MST_LOW_SUM   = 9;
    localparam int unsigned MST_CROSS_SUM = 10;

    // Reset values disable limit checks
    localparam logic [15:0] HIGH_BOUND_RESET = 16'h7ff8;
    localparam logic [15:0] LOW_BOUND_RESET  = 16'h0000;

    // Crossing type encodings
    localparam logic [1:0] CROSS_OFF      = 2'b00;
    localparam logic [1:0] CROSS_POS_NEG  = 2'b01;
    localparam logic [1:0] CROSS_NEG_POS  = 2'b10;
    localparam logic [1:0] CROSS_ANY      = 2'b11;

endpackage

// File: bench/adc_post_checker.sv
/* Checker for APB timing, read formats and irq stability.
   Sees only the ports of the post-processing block; bound below. */
`timescale 1ns/1ns
module adc_post_checker import adc_post_pkg::*; (
    input wire logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic        pready_o, pslverr_o, irq_o, conv_valid_i,
    input wire logic [2:0]  conv_slot_i,
    input wire logic [15:0] conv_raw_i
);
    logic [2:0] quiet;
    // Cycles since a strobe or write could move irq
    always_ff @(posedge clk_i) begin
        if (!rstn_i || conv_valid_i || (psel_i && pwrite_i))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    sequence take_s;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence done_s;
        pready_o ##1 !pready_o;
    endsequence
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    answer_pulse_a: assert property (
        take_s |=> done_s)
        else $error("pready not a pulse one cycle after access");
    no_stray_ready_a: assert property (
        pready_o |-> $past(psel_i && penable_i))
        else $error("pready without access");
    idle_data_zero_a: assert property (
        !pready_o |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("read data or error outside answer");
    upper_half_zero_a: assert property (
        pready_o |-> prdata_o[31:16] == 16'h0)
        else $error("upper read bits not zero");
    result_low_zero_a: assert property (
        pready_o && paddr_i[11:5] == 7'h02 |-> prdata_o[2:0] == 3'h0 && !pslverr_o)
        else $error("result low bits not zero");
    bound_masked_a: assert property (
        pready_o && paddr_i[11:6] == 6'h02 |-> (prdata_o & ~32'h7ff8) == 32'h0)
        else $error("bound reads outside field");
    cross_reserved_a: assert property (
        pready_o && paddr_i == ADDR_ZERO_CROSS_STAT |-> prdata_o[15:8] == 8'h0)
        else $error("crossing status reserved bits set");
    unmapped_error_a: assert property (
        pready_o && paddr_i == 12'hffc |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    irq_sticky_a: assert property (
        quiet >= 3'h3 |-> $stable(irq_o))
        else $error("irq moved without cause");
endmodule
bind adc_result_limit_zero_cross adc_post_checker i_adc_post_checker (.clk_i(clk_i),
    .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .conv_valid_i(conv_valid_i),
    .conv_slot_i(conv_slot_i), .conv_raw_i(conv_raw_i));

// File: bench/test_adc_result_limit_zero_cross.sv
/* Self-checking bench for the post-processing block.
   Drives APB and conversion strobes itself; no partner model. */
`timescale 1ns/1ns
module test_adc_result_limit_zero_cross import adc_post_pkg::*;;
    logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, conv_valid_i;
    logic        pready_o, pslverr_o, irq_o, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [2:0]  conv_slot_i;
    logic [15:0] conv_raw_i;
    int          bad_count = 0;
    int          n_checks = 0;
    adc_result_limit_zero_cross i_adc_result_limit_zero_cross (.clk_i(clk_i),
        .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .conv_valid_i(conv_valid_i), .conv_slot_i(conv_slot_i),
        .conv_raw_i(conv_raw_i), .irq_o(irq_o));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Entered just after an edge; leaves one idle cycle so no signal is set twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n == 20) begin
            bad_count++;
            $display("BAD pready expected 1 seen %b", pready_o);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic conv(input logic [2:0] s, input logic [15:0] raw);
        conv_valid_i <= 1'b1;
        conv_slot_i <= s;
        conv_raw_i <= raw;
        @(posedge clk_i);
        conv_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rdchk(ADDR_HIGH_BASE + 12'(4 * i), 32'(HIGH_BOUND_RESET), "high");
            rdchk(ADDR_LOW_BASE + 12'(4 * i), 32'(LOW_BOUND_RESET), "low");
        end
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b1, 12'hffc, 32'hffffffff);
        chk("unmapped write error", 32'h1, 32'(err));
        $display("reset test done");
    endtask
    task automatic t_result();
        apb(1'b1, ADDR_OFFSET_BASE + 12'h008, 32'h0100);
        conv(3'h2, 16'h0807);
        rdchk(ADDR_MAIN_STATUS, 32'h0004, "ready set");
        rdchk(ADDR_RESULT_BASE + 12'h008, 32'h0700, "result");
        rdchk(ADDR_MAIN_STATUS, 32'h0000, "ready read clear");
        conv(3'h2, 16'h0080);
        rdchk(ADDR_RESULT_BASE + 12'h008, 32'hff80, "negative");
        apb(1'b1, ADDR_RESULT_BASE + 12'h008, 32'hffffffff);
        rdchk(ADDR_RESULT_BASE + 12'h008, 32'h7ef8, "sw write");
        // Slots 0 and 4 keep zero offset, so results stay unsigned
        conv(3'h0, 16'h7fff);
        conv(3'h4, 16'h0000);
        rdchk(ADDR_RESULT_BASE, 32'h7ff8, "pair first");
        rdchk(ADDR_RESULT_BASE + 12'h010, 32'h0000, "pair second");
        rdchk(ADDR_LIMIT_STATUS, 32'h0000, "checks off");
        $display("result test done");
    endtask
    task automatic t_limit();
        apb(1'b1, ADDR_HIGH_BASE + 12'h004, 32'h4000);
        apb(1'b1, ADDR_LOW_BASE + 12'h004, 32'h1000);
        apb(1'b1, ADDR_OFFSET_BASE + 12'h004, 32'h2000);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0001);
        conv(3'h1, 16'h4000);
        rdchk(ADDR_LIMIT_STATUS, 32'h0000, "equal high");
        conv(3'h1, 16'h4008);
        chk("irq high", 32'h1, 32'(irq_o));
        conv(3'h1, 16'h0ff8);
        apb(1'b1, ADDR_LIMIT_STATUS, 32'h0000);
        rdchk(ADDR_LIMIT_STATUS, 32'h0202, "raw compare");
        apb(1'b1, ADDR_LIMIT_STATUS, 32'h0200);
        rdchk(ADDR_MAIN_STATUS, 32'h0202, "summary");
        chk("irq cleared", 32'h0, 32'(irq_o));
        // Low flag of slot 1 is still up, so the low enable alone raises irq
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0002);
        chk("irq low", 32'h1, 32'(irq_o));
        $display("limit test done");
    endtask
    task automatic t_cross();
        apb(1'b1, ADDR_CROSSING_CONTROL, 32'he400);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0004);
        for (int s = 4; s < 8; s++)
            conv(3'(s), 16'h0008);
        for (int s = 4; s < 8; s++)
            conv(3'(s), 16'h4008);
        rdchk(ADDR_ZERO_CROSS_STAT, 32'h00a0, "to negative");
        chk("irq cross", 32'h1, 32'(irq_o));
        for (int s = 4; s < 8; s++)
            conv(3'(s), 16'h0008);
        rdchk(ADDR_ZERO_CROSS_STAT, 32'h00e0, "to positive");
        apb(1'b1, ADDR_ZERO_CROSS_STAT, 32'h00ff);
        rdchk(ADDR_ZERO_CROSS_STAT, 32'h0000, "cleared");
        $display("crossing test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, conv_valid_i} = 5'h0;
        {paddr_i, pwdata_i, conv_slot_i, conv_raw_i} = '0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_result();
        t_limit();
        t_cross();
        report_and_stop();
    end
    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end
endmodule
